/* File: crsr_pkg.sv */
package crsr_pkg;
  localparam int CRSR_XLEN = 32;
  localparam int CRSR_NUM_GPR = 32;
  localparam logic [4:0] CRSR_ZERO_IDX = 5'h00;
  localparam logic [4:0] CRSR_LINK_IDX = 5'h1f;
  localparam logic [31:0] CRSR_LINK_OFFSET = 32'h0000_0008;
  localparam logic [4:0] CRSR_SC_HW_SETUP = 5'h03;
  localparam logic [4:0] CRSR_SC_CACHE_LOCK = 5'h07;
  localparam logic [4:0] CRSR_SC_FAULT_VA = 5'h08;
  localparam logic [4:0] CRSR_SC_PROC_STATE = 5'h0c;
  localparam logic [4:0] CRSR_SC_EXC_REASON = 5'h0d;
  localparam logic [4:0] CRSR_SC_EXC_RET_PC = 5'h0e;
  localparam logic [4:0] CRSR_SC_REV_ID = 5'h0f;
  localparam logic [4:0] CRSR_SC_DEBUG_CTL = 5'h10;
  localparam logic [4:0] CRSR_SC_DEBUG_RET_PC = 5'h11;
  localparam logic [31:0] CRSR_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] CRSR_PC_RESET = 32'hbfc0_0000;
  localparam int CRSR_LOCK_BIT = 0;
  localparam int CRSR_NUM_COPROC = 3;
  typedef enum logic [2:0] {
    CRSR_MD_NONE = 3'b000,
    CRSR_MD_MULT = 3'b001,
    CRSR_MD_MULTU = 3'b010,
    CRSR_MD_DIV = 3'b011,
    CRSR_MD_DIVU = 3'b100,
    CRSR_MD_MADD = 3'b101,
    CRSR_MD_MADDU = 3'b110
  } crsr_md_op_t;
endpackage : crsr_pkg

/* File: crsr_core_regs.sv */
`timescale 1ns/1ps
module crsr_core_regs
  import crsr_pkg::*;
#(
  parameter logic [31:0] REV_ID_VALUE = 32'h0000_1234,
  parameter logic [31:0] HW_SETUP_RESET = 32'h0000_0000
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic jal_valid,
  input wire logic [31:0] jal_pc,
  input wire logic pc_load,
  input wire logic [31:0] pc_value,
  input wire logic [2:0] md_op,
  input wire logic [31:0] md_src_a,
  input wire logic [31:0] md_src_b,
  input wire logic upper_wr,
  input wire logic lower_wr,
  input wire logic ld_in_ex,
  input wire logic [4:0] ld_dest,
  input wire logic [4:0] id_src_a,
  input wire logic [4:0] id_src_b,
  input wire logic ld_miss,
  input wire logic ld_fill,
  input wire logic likely_branch,
  input wire logic likely_taken,
  input wire logic [1:0] cop_num,
  input wire logic [2:0] cop_present,
  input wire logic sc_move_to,
  input wire logic sc_move_from,
  input wire logic [4:0] sc_index,
  input wire logic [31:0] sc_wr_data,
  input wire logic addr_error,
  input wire logic [31:0] addr_error_va,
  input wire logic dma_cycle,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] snoop_tag,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b,
  output logic [31:0] pc_out,
  output logic [31:0] upper_out,
  output logic [31:0] lower_out,
  output logic stall_out,
  output logic miss_pending,
  output logic slot_squash,
  output logic cop_usable,
  output logic [31:0] sc_rd_data,
  output logic sc_rd_valid,
  output logic cache_set_locked,
  output logic snoop_invalidate
);
  logic [31:0] gpr_reg [CRSR_NUM_GPR];
  logic [31:0] pc_reg;
  logic [31:0] upper_reg;
  logic [31:0] lower_reg;
  logic [31:0] hw_setup_reg;
  logic [31:0] cache_lock_reg;
  logic [31:0] fault_virtual_address_reg;
  logic [31:0] proc_state_reg;
  logic [31:0] exc_reason_reg;
  logic [31:0] exception_return_pc_reg;
  logic [31:0] debug_ctl_reg;
  logic [31:0] debug_return_pc_reg;
  logic [31:0] rd_a_reg;
  logic [31:0] rd_b_reg;
  logic stall_reg;
  logic miss_reg;
  logic squash_reg;
  logic cop_reg;
  logic [31:0] sc_rd_reg;
  logic sc_valid_reg;
  logic snoop_reg;
  logic [4:0] miss_dest_reg;

  // Multiply/divide datapath
  wire logic signed [63:0] prod_signed = $signed(md_src_a) * $signed(md_src_b);
  wire logic [63:0] prod_unsigned = md_src_a * md_src_b;
  wire logic [63:0] acc_value = {upper_reg, lower_reg};
  wire logic div_zero = (md_src_b == CRSR_RESET_VALUE);
  wire logic [31:0] quot_s = div_zero ? CRSR_RESET_VALUE
    : 32'($signed(md_src_a) / $signed(md_src_b));
  wire logic [31:0] rem_s = div_zero ? md_src_a
    : 32'($signed(md_src_a) % $signed(md_src_b));
  wire logic [31:0] quot_u = div_zero ? CRSR_RESET_VALUE : md_src_a / md_src_b;
  wire logic [31:0] rem_u = div_zero ? md_src_a : md_src_a % md_src_b;
  logic [63:0] md_next;
  logic md_write;
  always_comb
  begin
    md_next = acc_value;
    md_write = 1'b1;
    unique case (md_op)
      CRSR_MD_MULT: md_next = prod_signed;
      CRSR_MD_MULTU: md_next = prod_unsigned;
      CRSR_MD_DIV: md_next = {rem_s, quot_s};
      CRSR_MD_DIVU: md_next = {rem_u, quot_u};
      CRSR_MD_MADD: md_next = acc_value + 64'(prod_signed);
      CRSR_MD_MADDU: md_next = acc_value + prod_unsigned;
      default: md_write = 1'b0;
    endcase
  end

  // Write port steering
  wire logic link_wr = jal_valid;
  wire logic [31:0] link_value = jal_pc + CRSR_LINK_OFFSET;
  wire logic gpr_we = wr_en && (wr_addr != CRSR_ZERO_IDX);
  wire logic [31:0] rd_a_next = (rd_addr_a == CRSR_ZERO_IDX) ? CRSR_RESET_VALUE
    : gpr_reg[rd_addr_a];
  wire logic [31:0] rd_b_next = (rd_addr_b == CRSR_ZERO_IDX) ? CRSR_RESET_VALUE
    : gpr_reg[rd_addr_b];

  // Hazard detection
  wire logic use_a = (id_src_a != CRSR_ZERO_IDX) && (id_src_a == ld_dest);
  wire logic use_b = (id_src_b != CRSR_ZERO_IDX) && (id_src_b == ld_dest);
  wire logic miss_use = miss_reg && ((id_src_a == miss_dest_reg)
    || (id_src_b == miss_dest_reg)) && (miss_dest_reg != CRSR_ZERO_IDX);
  wire logic stall_next = (ld_in_ex && (use_a || use_b)) || (miss_use && !ld_fill);
  wire logic miss_next = (miss_reg && !ld_fill) || (ld_miss && ld_in_ex);
  wire logic squash_next = likely_branch && !likely_taken;
  wire logic cop_next = (cop_num == 2'd0) || cop_present[cop_num - 2'd1];

  // Control unit access
  wire logic sc_wr = sc_move_to && !stall_next;
  logic [31:0] sc_read_mux;
  always_comb
  begin
    unique case (sc_index)
      CRSR_SC_HW_SETUP: sc_read_mux = hw_setup_reg;
      CRSR_SC_CACHE_LOCK: sc_read_mux = cache_lock_reg;
      CRSR_SC_FAULT_VA: sc_read_mux = fault_virtual_address_reg;
      CRSR_SC_PROC_STATE: sc_read_mux = proc_state_reg;
      CRSR_SC_EXC_REASON: sc_read_mux = exc_reason_reg;
      CRSR_SC_EXC_RET_PC: sc_read_mux = exception_return_pc_reg;
      CRSR_SC_REV_ID: sc_read_mux = REV_ID_VALUE;
      CRSR_SC_DEBUG_CTL: sc_read_mux = debug_ctl_reg;
      CRSR_SC_DEBUG_RET_PC: sc_read_mux = debug_return_pc_reg;
      default: sc_read_mux = CRSR_RESET_VALUE;
    endcase
  end

  // Snoop: invalidate when a DMA address hits a cached tag
  wire logic snoop_next = dma_cycle && (dma_addr == snoop_tag);

  // All state held while clk_en is low (stopped clock)
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < CRSR_NUM_GPR; i++)
      begin
        gpr_reg[i] <= CRSR_RESET_VALUE;
      end
    end
    else if (clk_en)
    begin
      if (gpr_we)
      begin
        gpr_reg[wr_addr] <= wr_data;
      end
      if (link_wr)
      begin
        gpr_reg[CRSR_LINK_IDX] <= link_value;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pc_reg <= CRSR_PC_RESET;
      upper_reg <= CRSR_RESET_VALUE;
      lower_reg <= CRSR_RESET_VALUE;
    end
    else if (clk_en)
    begin
      if (pc_load && !stall_next)
      begin
        pc_reg <= pc_value;
      end
      if (md_write)
      begin
        upper_reg <= md_next[63:32];
        lower_reg <= md_next[31:0];
      end
      else
      begin
        if (upper_wr)
        begin
          upper_reg <= md_src_a;
        end
        if (lower_wr)
        begin
          lower_reg <= md_src_a;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hw_setup_reg <= HW_SETUP_RESET;
      cache_lock_reg <= CRSR_RESET_VALUE;
      fault_virtual_address_reg <= CRSR_RESET_VALUE;
      proc_state_reg <= CRSR_RESET_VALUE;
      exc_reason_reg <= CRSR_RESET_VALUE;
      exception_return_pc_reg <= CRSR_RESET_VALUE;
      debug_ctl_reg <= CRSR_RESET_VALUE;
      debug_return_pc_reg <= CRSR_RESET_VALUE;
    end
    else if (clk_en)
    begin
      if (sc_wr && sc_index == CRSR_SC_HW_SETUP)
      begin
        hw_setup_reg <= sc_wr_data;
      end
      if (sc_wr && sc_index == CRSR_SC_CACHE_LOCK)
      begin
        cache_lock_reg <= sc_wr_data;
      end
      if (addr_error)
      begin
        fault_virtual_address_reg <= addr_error_va;
      end
      if (sc_wr && sc_index == CRSR_SC_PROC_STATE)
      begin
        proc_state_reg <= sc_wr_data;
      end
      if (sc_wr && sc_index == CRSR_SC_EXC_REASON)
      begin
        exc_reason_reg <= sc_wr_data;
      end
      if (sc_wr && sc_index == CRSR_SC_EXC_RET_PC)
      begin
        exception_return_pc_reg <= sc_wr_data;
      end
      if (sc_wr && sc_index == CRSR_SC_DEBUG_CTL)
      begin
        debug_ctl_reg <= sc_wr_data;
      end
      if (sc_wr && sc_index == CRSR_SC_DEBUG_RET_PC)
      begin
        debug_return_pc_reg <= sc_wr_data;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rd_a_reg <= CRSR_RESET_VALUE;
      rd_b_reg <= CRSR_RESET_VALUE;
      stall_reg <= 1'b0;
      miss_reg <= 1'b0;
      miss_dest_reg <= CRSR_ZERO_IDX;
      squash_reg <= 1'b0;
      cop_reg <= 1'b0;
      sc_rd_reg <= CRSR_RESET_VALUE;
      sc_valid_reg <= 1'b0;
      snoop_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_a_reg <= rd_a_next;
      rd_b_reg <= rd_b_next;
      stall_reg <= stall_next;
      miss_reg <= miss_next;
      if (ld_miss && ld_in_ex)
      begin
        miss_dest_reg <= ld_dest;
      end
      squash_reg <= squash_next;
      cop_reg <= cop_next;
      sc_valid_reg <= sc_move_from;
      if (sc_move_from)
      begin
        sc_rd_reg <= sc_read_mux;
      end
      snoop_reg <= snoop_next;
    end
  end

  assign rd_data_a = rd_a_reg;
  assign rd_data_b = rd_b_reg;
  assign pc_out = pc_reg;
  assign upper_out = upper_reg;
  assign lower_out = lower_reg;
  assign stall_out = stall_reg;
  assign miss_pending = miss_reg;
  assign slot_squash = squash_reg;
  assign cop_usable = cop_reg;
  assign sc_rd_data = sc_rd_reg;
  assign sc_rd_valid = sc_valid_reg;
  assign cache_set_locked = cache_lock_reg[CRSR_LOCK_BIT];
  assign snoop_invalidate = snoop_reg;

  zero_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && rd_addr_a == CRSR_ZERO_IDX |=> rd_data_a == 32'h0000_0000)
    else $error("zero register read nonzero");
  link_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && jal_valid |=> gpr_reg[CRSR_LINK_IDX] == $past(jal_pc) + 32'h0000_0008)
    else $error("link value wrong");
  mult_split_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && md_op == CRSR_MD_MULTU
    |=> {upper_out, lower_out} == $past(md_src_a) * $past(md_src_b))
    else $error("product split wrong");
  div_place_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && md_op == CRSR_MD_DIVU && md_src_b != 32'h0000_0000
    |=> lower_out == $past(md_src_a) / $past(md_src_b)
    && upper_out == $past(md_src_a) % $past(md_src_b))
    else $error("divide placement wrong");
  load_stall_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && ld_in_ex && id_src_a == ld_dest && ld_dest != 5'h00 |=> stall_out)
    else $error("load use not stalled");
  miss_track_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && ld_in_ex && ld_miss && !ld_fill |=> miss_pending)
    else $error("miss not tracked");
  fault_cap_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && addr_error |=> fault_virtual_address_reg == $past(addr_error_va))
    else $error("fault address not captured");
  reserved_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && sc_move_from && sc_index == 5'h01 |=> sc_rd_data == 32'h0000_0000)
    else $error("reserved index not zero");
  clock_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !clk_en |=> $stable(pc_out) && $stable(upper_out) && $stable(lower_out))
    else $error("state changed while stopped");
endmodule : crsr_core_regs

/* File: crsr_far_side.sv */
`timescale 1ns/1ps
// Memory side answering load misses, plus attached coprocessors
module crsr_far_side
  import crsr_pkg::*;
#(
  parameter int FILL_DELAY = 3
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ld_miss,
  output logic ld_fill,
  output logic [2:0] cop_present
);
  int count = 0;
  // Only the second coprocessor is fitted
  assign cop_present = 3'b010;
  always @(posedge clock)
  begin
    ld_fill <= 1'b0;
    if (sys_rst)
      count <= 0;
    else if (ld_miss)
      count <= FILL_DELAY;
    else if (count == 1)
    begin
      count <= 0;
      ld_fill <= 1'b1;
    end
    else if (count > 0)
      count <= count - 1;
  end
endmodule : crsr_far_side

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import crsr_pkg::*;
  // Arbitrary revision value
  localparam logic [31:0] REV = 32'h0000_5a5a;
  typedef struct {logic [2:0] op; logic [31:0] a, b, hi, lo;} crsr_row_t;
  logic clock = 1'b0, clk_stop = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic wr_en = 1'b0, jal_valid = 1'b0, pc_load = 1'b0, upper_wr = 1'b0, lower_wr = 1'b0;
  logic ld_in_ex = 1'b0, ld_miss = 1'b0, likely_branch = 1'b0, likely_taken = 1'b0;
  logic sc_move_to = 1'b0, sc_move_from = 1'b0, addr_error = 1'b0, dma_cycle = 1'b0;
  logic [4:0] rd_addr_a = 5'h00, rd_addr_b = 5'h00, wr_addr = 5'h00, ld_dest = 5'h00;
  logic [4:0] id_src_a = 5'h00, id_src_b = 5'h00, sc_index = 5'h00;
  logic [1:0] cop_num = 2'h0;
  logic [2:0] md_op = 3'h0;
  logic [31:0] wr_data = 32'h0000_0000, jal_pc = 32'h0000_0000, pc_value = 32'h0000_0000;
  logic [31:0] md_src_a = 32'h0000_0000, md_src_b = 32'h0000_0000, sc_wr_data = 32'h0000_0000;
  logic [31:0] addr_error_va = 32'h0000_0000, dma_addr = 32'h0000_0000;
  logic [31:0] snoop_tag = 32'h0000_0000;
  logic ld_fill, stall_out, miss_pending, slot_squash, cop_usable, sc_rd_valid;
  logic cache_set_locked, snoop_invalidate;
  logic [2:0] cop_present;
  logic [31:0] rd_data_a, rd_data_b, pc_out, upper_out, lower_out, sc_rd_data;
  int n_errors = 0;
  int n_compared = 0;
  crsr_row_t rows [8] = '{
    '{CRSR_MD_MULT, 32'hffff_fffd, 32'h0000_0005, 32'hffff_ffff, 32'hffff_fff1},
    '{CRSR_MD_MULTU, 32'hffff_ffff, 32'h0000_0002, 32'h0000_0001, 32'hffff_fffe},
    '{CRSR_MD_DIV, 32'hffff_fff9, 32'h0000_0002, 32'hffff_ffff, 32'hffff_fffd},
    '{CRSR_MD_DIVU, 32'h0000_0007, 32'h0000_0002, 32'h0000_0001, 32'h0000_0003},
    '{CRSR_MD_MADDU, 32'h0000_0003, 32'h0000_0004, 32'h0000_0001, 32'h0000_000f},
    '{CRSR_MD_MADD, 32'hffff_ffff, 32'h0000_0001, 32'h0000_0001, 32'h0000_000e},
    '{CRSR_MD_MADD, 32'h8000_0000, 32'h0000_0002, 32'h0000_0000, 32'h0000_000e},
    '{CRSR_MD_DIVU, 32'h0000_0005, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000}};
  logic [4:0] sx [15] = '{5'h03, 5'h07, 5'h08, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11,
    5'h00, 5'h01, 5'h04, 5'h09, 5'h12, 5'h1f};
  logic [31:0] wv [15] = '{32'h0000_0003, 32'h0000_0001, 32'hffff_ffff, 32'h0000_0401,
    32'h0000_007c, 32'h8000_0180, 32'hffff_ffff, 32'h0000_0002, 32'h8000_0200,
    32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
    32'hffff_ffff};
  logic [31:0] sv [15] = '{32'h0000_0003, 32'h0000_0001, 32'h0bad_0040, 32'h0000_0401,
    32'h0000_007c, 32'h8000_0180, REV, 32'h0000_0002, 32'h8000_0200, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  crsr_core_regs #(.REV_ID_VALUE(REV), .HW_SETUP_RESET(32'h0000_0000)) i_crsr_core_regs (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .rd_addr_a(rd_addr_a),
    .rd_addr_b(rd_addr_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .jal_valid(jal_valid), .jal_pc(jal_pc), .pc_load(pc_load), .pc_value(pc_value),
    .md_op(md_op), .md_src_a(md_src_a), .md_src_b(md_src_b), .upper_wr(upper_wr),
    .lower_wr(lower_wr), .ld_in_ex(ld_in_ex), .ld_dest(ld_dest), .id_src_a(id_src_a),
    .id_src_b(id_src_b), .ld_miss(ld_miss), .ld_fill(ld_fill), .likely_branch(likely_branch),
    .likely_taken(likely_taken), .cop_num(cop_num), .cop_present(cop_present),
    .sc_move_to(sc_move_to), .sc_move_from(sc_move_from), .sc_index(sc_index),
    .sc_wr_data(sc_wr_data), .addr_error(addr_error), .addr_error_va(addr_error_va),
    .dma_cycle(dma_cycle), .dma_addr(dma_addr), .snoop_tag(snoop_tag),
    .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .pc_out(pc_out), .upper_out(upper_out),
    .lower_out(lower_out), .stall_out(stall_out), .miss_pending(miss_pending),
    .slot_squash(slot_squash), .cop_usable(cop_usable), .sc_rd_data(sc_rd_data),
    .sc_rd_valid(sc_rd_valid), .cache_set_locked(cache_set_locked),
    .snoop_invalidate(snoop_invalidate));
  crsr_far_side #(.FILL_DELAY(3)) i_crsr_far_side (.clock(clock), .sys_rst(sys_rst),
    .ld_miss(ld_miss), .ld_fill(ld_fill), .cop_present(cop_present));

  // Clock can be parked high only
  initial
  begin
    forever #25 if (!clk_stop || !clock) clock = ~clock;
  end

  task automatic cyc;
    @(posedge clock);
    @(negedge clock);
  endtask : cyc

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #(3000 * 50);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    chk("pc_out", CRSR_PC_RESET, pc_out);
    chk("lower_out", 32'h0000_0000, lower_out);
    $display("Test reset done");
    foreach (rows[i])
    begin
      md_op = rows[i].op;
      md_src_a = rows[i].a;
      md_src_b = rows[i].b;
      cyc();
      chk("upper_out", rows[i].hi, upper_out);
      chk("lower_out", rows[i].lo, lower_out);
    end
    md_op = CRSR_MD_NONE;
    upper_wr = 1'b1;
    lower_wr = 1'b1;
    md_src_a = 32'h0c0c_0c0c;
    cyc();
    upper_wr = 1'b0;
    lower_wr = 1'b0;
    chk("upper_out", 32'h0c0c_0c0c, upper_out);
    chk("lower_out", 32'h0c0c_0c0c, lower_out);
    $display("Test multiply divide done");
    wr_en = 1'b1;
    wr_data = 32'hdead_beef;
    cyc();
    wr_addr = 5'h05;
    wr_data = 32'h1234_5678;
    cyc();
    wr_addr = 5'h1f;
    wr_data = 32'h5555_5555;
    jal_valid = 1'b1;
    jal_pc = 32'h0000_1000;
    cyc();
    wr_en = 1'b0;
    jal_valid = 1'b0;
    rd_addr_b = 5'h1f;
    cyc();
    chk("rd_data_a", 32'h0000_0000, rd_data_a);
    chk("rd_data_b", 32'h0000_1008, rd_data_b);
    rd_addr_a = 5'h05;
    cyc();
    chk("rd_data_a", 32'h1234_5678, rd_data_a);
    $display("Test registers done");
    ld_in_ex = 1'b1;
    ld_dest = 5'h07;
    id_src_a = 5'h07;
    cyc();
    chk("stall_out", 32'h0000_0001, {31'h0, stall_out});
    id_src_a = 5'h02;
    id_src_b = 5'h07;
    cyc();
    chk("stall_out", 32'h0000_0001, {31'h0, stall_out});
    id_src_b = 5'h04;
    cyc();
    chk("stall_out", 32'h0000_0000, {31'h0, stall_out});
    ld_miss = 1'b1;
    cyc();
    ld_in_ex = 1'b0;
    ld_miss = 1'b0;
    pc_load = 1'b1;
    pc_value = 32'h0000_0400;
    cyc();
    pc_load = 1'b0;
    chk("pc_out", 32'h0000_0400, pc_out);
    chk("miss_pending", 32'h0000_0001, {31'h0, miss_pending});
    for (int k = 0; k < 10 && miss_pending !== 1'b0; k++)
      cyc();
    chk("miss_pending", 32'h0000_0000, {31'h0, miss_pending});
    $display("Test pipeline done");
    likely_branch = 1'b1;
    cyc();
    chk("slot_squash", 32'h0000_0001, {31'h0, slot_squash});
    likely_taken = 1'b1;
    cyc();
    chk("slot_squash", 32'h0000_0000, {31'h0, slot_squash});
    likely_branch = 1'b0;
    for (int n = 0; n < 4; n++)
    begin
      cop_num = n[1:0];
      cyc();
      chk("cop_usable", 32'(n % 2 == 0), {31'h0, cop_usable});
    end
    $display("Test branch coprocessor done");
    addr_error = 1'b1;
    addr_error_va = 32'h0bad_0040;
    cyc();
    addr_error = 1'b0;
    sc_move_to = 1'b1;
    foreach (sx[i])
    begin
      sc_index = sx[i];
      sc_wr_data = wv[i];
      cyc();
    end
    sc_move_to = 1'b0;
    chk("cache_set_locked", 32'h0000_0001, {31'h0, cache_set_locked});
    sc_move_from = 1'b1;
    foreach (sx[i])
    begin
      sc_index = sx[i];
      cyc();
      chk("sc_rd_valid", 32'h0000_0001, {31'h0, sc_rd_valid});
      chk("sc_rd_data", sv[i], sc_rd_data);
    end
    sc_move_from = 1'b0;
    $display("Test control unit done");
    dma_cycle = 1'b1;
    dma_addr = 32'h0000_2000;
    snoop_tag = 32'h0000_2000;
    cyc();
    chk("snoop_invalidate", 32'h0000_0001, {31'h0, snoop_invalidate});
    snoop_tag = 32'h0000_2004;
    cyc();
    chk("snoop_invalidate", 32'h0000_0000, {31'h0, snoop_invalidate});
    dma_cycle = 1'b0;
    clk_en = 1'b0;
    pc_load = 1'b1;
    pc_value = 32'h0000_0800;
    cyc();
    chk("pc_out", 32'h0000_0400, pc_out);
    clk_en = 1'b1;
    cyc();
    pc_load = 1'b0;
    clk_stop = 1'b1;
    #410;
    clk_stop = 1'b0;
    @(negedge clock);
    chk("pc_out", 32'h0000_0800, pc_out);
    chk("upper_out", 32'h0c0c_0c0c, upper_out);
    sys_rst = 1'b1;
    cyc();
    sys_rst = 1'b0;
    chk("pc_out", CRSR_PC_RESET, pc_out);
    chk("upper_out", 32'h0000_0000, upper_out);
    $display("Test clock stop and reset done");
    wrap_up();
  end
endmodule : testbench
